// File: hdl/subtract_datapath.sv
// Purpose: Subtract slice of an 8-bit core: literal and file forms
// Assumes: Decoder presents instr_word with file_rd_data in one cycle
// Notes: Flags are outputs; status storage lives elsewhere
`timescale 1ns/1ps
module subtract_datapath #(
   parameter int data_w = subtract_pkg::data_w,
   parameter int addr_w = subtract_pkg::addr_w
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic instr_valid,
   input wire logic [subtract_pkg::instr_w-1:0] instr_word,
   input wire logic [data_w-1:0] file_rd_data,
   output logic [addr_w-1:0] file_addr,
   output logic [data_w-1:0] file_wr_data,
   output logic file_wr_en,
   output logic [data_w-1:0] accumulator,
   output logic carry_flag,
   output logic nibble_borrow_flag,
   output logic zero_flag,
   output logic flags_valid
);
   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   // Operation picked out of the word standing this cycle
   subtract_pkg::op_kind_t op_kind;
   logic dest_file;
   logic [data_w-1:0] minuend;

   // Subtractor outputs, all combinational
   logic [data_w-1:0] difference;
   logic no_borrow;
   logic nibble_no_borrow;
   logic is_zero;

   // Working register
   logic [data_w-1:0] accumulator_q;
   logic [data_w-1:0] accumulator_d;

   // File write-back
   logic [data_w-1:0] file_wr_data_q;
   logic [data_w-1:0] file_wr_data_d;
   logic file_wr_en_q;
   logic file_wr_en_d;

   // Flags
   logic carry_q;
   logic carry_d;
   logic nibble_q;
   logic nibble_d;
   logic zero_q;
   logic zero_d;
   logic flags_valid_q;
   logic flags_valid_d;

   // Literal form leaves bit 8 free, so only five bits are matched
   function automatic logic is_literal(input logic [subtract_pkg::instr_w-1:0] word);
      is_literal = (word[subtract_pkg::lit_op_msb:subtract_pkg::lit_op_lsb]
            == subtract_pkg::lit_op_code);
   endfunction

   function automatic logic is_file(input logic [subtract_pkg::instr_w-1:0] word);
      is_file = (word[subtract_pkg::file_op_msb:subtract_pkg::file_op_lsb]
            == subtract_pkg::file_op_code);
   endfunction

   // Shared by both write-back groups so they can never disagree on the target
   function automatic logic to_file(input subtract_pkg::op_kind_t kind, input logic dest);
      to_file = (kind == subtract_pkg::op_file) && dest;
   endfunction

   // File address is a plain decode of the word so the register file can read
   assign file_addr = instr_word[addr_w-1:0];

   // Literal match wins; the two patterns never overlap anyway
   always_comb begin
      op_kind = subtract_pkg::op_none;
      dest_file = instr_word[subtract_pkg::dest_bit];
      if (instr_valid) begin
         if (is_literal(instr_word)) begin
            op_kind = subtract_pkg::op_literal;
         end else if (is_file(instr_word)) begin
            op_kind = subtract_pkg::op_file;
         end
      end
   end

   // Idle minuend is zero so the adder does not toggle on foreign words
   always_comb begin
      case (op_kind)
         subtract_pkg::op_literal: begin
            minuend = instr_word[data_w-1:0];
         end
         subtract_pkg::op_file: begin
            minuend = file_rd_data;
         end
         default: begin
            minuend = '0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Subtractor
   // -----------------------------------------------------------------
   // Accumulator is always the subtrahend in both forms
   sub_core #(
      .width(data_w)
   ) u_sub (
      .minuend(minuend),
      .subtrahend(accumulator_q),
      .difference(difference),
      .no_borrow(no_borrow),
      .nibble_no_borrow(nibble_no_borrow),
      .is_zero(is_zero)
   );

   // -----------------------------------------------------------------
   // Working register
   // -----------------------------------------------------------------
   always_comb begin
      accumulator_d = accumulator_q;
      case (op_kind)
         subtract_pkg::op_literal: begin
            accumulator_d = difference;
         end
         subtract_pkg::op_file: begin
            if (!to_file(op_kind, dest_file)) begin
               accumulator_d = difference;
            end
         end
         default: begin
            accumulator_d = accumulator_q;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         accumulator_q <= data_w'(subtract_pkg::acc_reset);
      end else if (clk_en) begin
         accumulator_q <= accumulator_d;
      end
   end

   // -----------------------------------------------------------------
   // File write-back
   // -----------------------------------------------------------------
   // Data holds its last value between writes; only the strobe pulses
   always_comb begin
      file_wr_data_d = file_wr_data_q;
      file_wr_en_d = 1'b0;
      if (to_file(op_kind, dest_file)) begin
         file_wr_data_d = difference;
         file_wr_en_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         file_wr_data_q <= data_w'(subtract_pkg::result_reset);
         file_wr_en_q <= subtract_pkg::flag_reset;
      end else if (clk_en) begin
         file_wr_data_q <= file_wr_data_d;
         file_wr_en_q <= file_wr_en_d;
      end
   end

   // Write strobe held low while frozen so a stalled cycle cannot double-write
   assign file_wr_en = file_wr_en_q & clk_en;
   assign file_wr_data = file_wr_data_q;

   // -----------------------------------------------------------------
   // Flags
   // -----------------------------------------------------------------
   // Carry and nibble flag mean no borrow, the inverse of a borrow bit
   always_comb begin
      carry_d = carry_q;
      nibble_d = nibble_q;
      zero_d = zero_q;
      flags_valid_d = 1'b0;
      case (op_kind)
         subtract_pkg::op_literal,
         subtract_pkg::op_file: begin
            carry_d = no_borrow;
            nibble_d = nibble_no_borrow;
            zero_d = is_zero;
            flags_valid_d = 1'b1;
         end
         default: begin
            flags_valid_d = 1'b0;
         end
      endcase
   end

   // Single-cycle completion: all results land on the edge after decode
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         carry_q <= subtract_pkg::flag_reset;
         nibble_q <= subtract_pkg::flag_reset;
         zero_q <= subtract_pkg::flag_reset;
         flags_valid_q <= subtract_pkg::flag_reset;
      end else if (clk_en) begin
         carry_q <= carry_d;
         nibble_q <= nibble_d;
         zero_q <= zero_d;
         flags_valid_q <= flags_valid_d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Flags stand until the next subtract; flags_valid marks the update
   assign accumulator = accumulator_q;
   assign carry_flag = carry_q;
   assign nibble_borrow_flag = nibble_q;
   assign zero_flag = zero_q;
   assign flags_valid = flags_valid_q;
endmodule

// File: hdl/subtract_pkg.sv
// Purpose: Shared constants for the subtract datapath slice
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes: Values after reset and opcode fields live here
package subtract_pkg;
   localparam int data_w = 8;
   localparam int addr_w = 7;
   localparam int instr_w = 14;
   // -----------------------------------------------------------------
   // Opcode fields
   // -----------------------------------------------------------------
   localparam int lit_op_msb = 13;
   localparam int lit_op_lsb = 9;
   localparam logic [4:0] lit_op_code = 5'h1e;
   localparam int file_op_msb = 13;
   localparam int file_op_lsb = 8;
   localparam logic [5:0] file_op_code = 6'h02;
   localparam int dest_bit = 7;
   localparam int nibble_w = 4;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] acc_reset = 8'h00;
   localparam logic [7:0] result_reset = 8'h00;
   localparam logic [6:0] addr_reset = 7'h00;
   localparam logic flag_reset = 1'b0;
   typedef enum logic [1:0] {
      op_none,
      op_literal,
      op_file
   } op_kind_t;
endpackage

// File: hdl/sub_core.sv
// Purpose: Combinational 8-bit subtractor with borrow flags
// Assumes: Operands valid in the same cycle
// Notes: Carry and nibble flag are active-high "no borrow"
`timescale 1ns/1ps
module sub_core #(
   parameter int width = 8
) (
   input wire logic [width-1:0] minuend,
   input wire logic [width-1:0] subtrahend,
   output logic [width-1:0] difference,
   output logic no_borrow,
   output logic nibble_no_borrow,
   output logic is_zero
);
   logic [width:0] full_sum;
   logic [subtract_pkg::nibble_w:0] low_sum;
   // Two's complement: a + ~b + 1, carry out means no borrow
   always_comb begin
      full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{width{1'b0}}, 1'b1};
      low_sum = {1'b0, minuend[subtract_pkg::nibble_w-1:0]}
         + {1'b0, ~subtrahend[subtract_pkg::nibble_w-1:0]}
         + {{subtract_pkg::nibble_w{1'b0}}, 1'b1};
      difference = full_sum[width-1:0];
      no_borrow = full_sum[width];
      nibble_no_borrow = low_sum[subtract_pkg::nibble_w];
      is_zero = (full_sum[width-1:0] == '0);
   end
endmodule

// File: dv/regfile_model.sv
// Purpose: Register file seen by the subtract slice
// Assumes: Read follows file_addr at once
// Notes: Pending write is forwarded
`timescale 1ns/1ps
module regfile_model (
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_wr_data,
   input wire logic file_wr_en,
   output logic [7:0] file_rd_data
);
   logic [7:0] mem [128];
   logic [6:0] addr_q;
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
   // Back-to-back ops on one f must see the write still in flight
   assign file_rd_data = (file_wr_en && addr_q == file_addr) ? file_wr_data : mem[file_addr];
   always @(posedge ref_clk) begin
      // Address latch freezes with the core so a held write hits its own f
      if (clk_en) addr_q <= file_addr;
      if (file_wr_en) mem[addr_q] <= file_wr_data;
   end
endmodule

// File: dv/subtract_datapath_asserts.sv
// Purpose: Port checks for the subtract slice
// Assumes: One clock, sync reset
// Notes: Outputs judged on operands of the prior cycle
`timescale 1ns/1ps
module subtract_datapath_checker (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [7:0] file_rd_data,
   input wire logic [7:0] file_wr_data,
   input wire logic [7:0] accumulator,
   input wire logic [6:0] file_addr,
   input wire logic file_wr_en,
   input wire logic carry_flag,
   input wire logic nibble_borrow_flag,
   input wire logic zero_flag,
   input wire logic flags_valid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   wire lit = clk_en && instr_valid && instr_word[13:9] == 5'h1e;
   wire fil = clk_en && instr_valid && instr_word[13:8] == 6'h02;
   wire op = lit || fil;
   wire [7:0] m = lit ? instr_word[7:0] : file_rd_data;
   wire [7:0] dif = m - accumulator;
   wire nb = m >= accumulator;
   wire nib = m[3:0] >= accumulator[3:0];
   property p_file_to_acc;
      fil && !instr_word[7] |=> accumulator == $past(dif) && !file_wr_en;
   endproperty
   property p_file_to_reg;
      fil && instr_word[7] |=> file_wr_en && file_wr_data == $past(dif) && $stable(accumulator);
   endproperty
   property p_zero_nibble;
      op |=> zero_flag == ($past(dif) == 8'h00) && nibble_borrow_flag == $past(nib);
   endproperty
   // A frozen cycle holds flags_valid, so only judge edges that ran
   property p_one_cycle;
      $past(reset_n) && $past(clk_en) |-> flags_valid == $past(op);
   endproperty
   property p_refused_hold;
      clk_en && !op |=> $stable(accumulator) && !flags_valid && !file_wr_en;
   endproperty
   property p_stall_freeze;
      !clk_en |=> $stable(accumulator) && $stable(carry_flag) && $stable(zero_flag);
   endproperty
   a_lit_result: assert property (lit |=> accumulator == $past(dif))
      else $error("literal result wrong");
   a_file_to_acc: assert property (p_file_to_acc)
      else $error("file result to accumulator wrong");
   a_file_to_reg: assert property (p_file_to_reg)
      else $error("file result to register wrong");
   a_carry_borrow: assert property (op |=> carry_flag == $past(nb))
      else $error("carry wrong");
   a_zero_nibble: assert property (p_zero_nibble)
      else $error("zero or nibble flag wrong");
   a_one_cycle: assert property (p_one_cycle)
      else $error("flags_valid timing wrong");
   a_refused_hold: assert property (p_refused_hold)
      else $error("refused word changed state");
   a_stall_freeze: assert property (p_stall_freeze)
      else $error("state moved while frozen");
   a_addr_field: assert property (instr_valid |-> file_addr == instr_word[6:0])
      else $error("file address wrong");
   c_lit: cover property (lit);
   c_write: cover property (fil && instr_word[7]);
   c_zero: cover property (flags_valid && zero_flag);
   c_borrow: cover property (op && !nb);
   c_stall: cover property (!clk_en && instr_valid);
endmodule
bind subtract_datapath subtract_datapath_checker u_chk (
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .clk_en(clk_en),
   .instr_valid(instr_valid),
   .instr_word(instr_word),
   .file_rd_data(file_rd_data),
   .file_wr_data(file_wr_data),
   .accumulator(accumulator),
   .file_addr(file_addr),
   .file_wr_en(file_wr_en),
   .carry_flag(carry_flag),
   .nibble_borrow_flag(nibble_borrow_flag),
   .zero_flag(zero_flag),
   .flags_valid(flags_valid)
);

// File: dv/test_subtract_datapath.sv
// Purpose: Self-checking bench for the subtract slice
// Assumes: Partner register file answers at once
// Notes: Random mix of both forms, refused words, stalls
`timescale 1ns/1ps
module test_subtract_datapath;
   logic ref_clk = 0, reset_n = 0, clk_en = 1, instr_valid = 0;
   logic [13:0] instr_word = 14'h0000;
   logic [7:0] file_rd_data, file_wr_data, accumulator, acc = 8'h00, sh [128];
   logic [6:0] file_addr;
   logic file_wr_en, carry_flag, nibble_borrow_flag, zero_flag, flags_valid;
   logic [19:0] notes [$];
   logic [31:0] seed = 32'h40cf;
   logic [2:0] kind;
   int miscompares = 0, comparisons = 0;
   subtract_datapath u_dut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .file_rd_data(file_rd_data),
      .file_addr(file_addr),
      .file_wr_data(file_wr_data),
      .file_wr_en(file_wr_en),
      .accumulator(accumulator),
      .carry_flag(carry_flag),
      .nibble_borrow_flag(nibble_borrow_flag),
      .zero_flag(zero_flag),
      .flags_valid(flags_valid)
   );
   regfile_model u_rf (
      .ref_clk(ref_clk),
      .clk_en(clk_en),
      .file_addr(file_addr),
      .file_wr_data(file_wr_data),
      .file_wr_en(file_wr_en),
      .file_rd_data(file_rd_data)
   );
   // Result as seen at the ports, write data masked when no write
   wire [19:0] seen = {file_wr_en, file_wr_en ? file_wr_data : 8'h00, accumulator,
      carry_flag, nibble_borrow_flag, zero_flag};
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
   endfunction
   initial forever #25 ref_clk = ~ref_clk;
   task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results;
      if (miscompares == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic issue(logic [2:0] kd, logic [7:0] k, logic [6:0] f, logic b);
      logic [7:0] m;
      logic [7:0] d;
      logic wr;
      m = kd < 2 ? k : sh[f];
      d = m - acc;
      wr = kd > 3;
      instr_word = kd < 2 ? {5'h1e, b, k} : {6'h02, wr, f};
      if (clk_en) begin
         notes.push_back({wr, wr ? d : 8'h00, wr ? acc : d,
            m >= acc, m[3:0] >= acc[3:0], d == 8'h00});
         if (wr) sh[f] = d;
         else acc = d;
      end
   endtask
   always @(negedge ref_clk) begin
      if (flags_valid === 1'b1) begin
         chk("result", notes.pop_front(), seen);
      end
   end
   initial begin
      for (int i = 0; i < 128; i++) sh[i] = 8'(i * 37);
      // Second pass starts with a reset in mid-run; file contents survive it
      for (int run = 0; run < 2; run++) begin
         reset_n = 0;
         clk_en = 1;
         instr_valid = 0;
         repeat (10) @(negedge ref_clk);
         acc = 8'h00;
         reset_n = 1;
         instr_valid = 1;
         repeat (200) begin
            seed = xorshift(seed);
            kind = seed[2:0];
            clk_en = 1;
            // Refused word, then a stalled op that must not count
            if (kind > 5) begin
               instr_word = {6'h3f, seed[15:8]};
               @(negedge ref_clk);
               clk_en = 0;
               kind = 0;
            end
            issue(kind, kind == 1 ? acc : seed[15:8], seed[22:16], seed[3]);
            @(negedge ref_clk);
         end
      end
      instr_valid = 0;
      repeat (3) @(negedge ref_clk);
      chk("notes left", 20'h0, 20'(notes.size()));
      results;
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      miscompares++;
      results;
   end
endmodule
